/* File: logic/tpn_node.sv */
// token-pass node: network start, token claim, successor search, passing
`timescale 1ns/10ps
`default_nettype none
`include "tpn_defs.svh"
module tpn_node
  import tpn_pkg::*;
#(
  parameter int ADDR_W = `TPN_ADDR_W,
  parameter int TMR_W = 16,
  parameter logic [TMR_W-1:0] DEAD_CYCLES = `TPN_DEAD_CYCLES,
  parameter logic [TMR_W-1:0] REPLY_CYCLES = `TPN_REPLY_CYCLES
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  // configuration
  input wire logic I_IS_INITIATOR,
  input wire logic I_CFG_LOAD,
  input wire logic [ADDR_W-1:0] I_CFG_ADDR,
  input wire logic [ADDR_W-1:0] I_CFG_MAX_ADDR,
  input wire logic [2:0] I_CFG_HOLD,
  // link events
  input wire logic I_LINK_ACTIVITY,
  input wire logic I_TOKEN_RX,
  input wire logic I_TX_DONE,
  // application
  input wire logic I_MSG_PENDING,
  // link requests
  output logic O_SEND_MSG,
  output logic O_SEND_PASS,
  output logic [ADDR_W-1:0] O_DEST_ADDR,
  // status
  output logic [ADDR_W-1:0] O_NODE_ADDR,
  output logic [ADDR_W-1:0] O_MAX_ADDR,
  output logic O_HAS_TOKEN,
  output logic O_NET_NORMAL,
  output logic O_CFG_ERR
);
  typedef struct packed {
    tpn_state_t state;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] max_addr;
    logic [2:0] hold;
    logic [ADDR_W-1:0] succ;
    logic succ_ok;
    logic [ADDR_W-1:0] target;
    logic [1:0] tries;
    logic [2:0] sent;
    logic origin;
    logic normal;
    logic cfg_err;
    logic send_msg;
    logic send_pass;
    logic fresh;
  } tpn_st_t;
  tpn_st_t st;
  tpn_st_t next_st;

  logic dead;
  logic reply_late;
  logic restart_dead;
  logic restart_reply;

  // next address with wrap past the maximum
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [ADDR_W-1:0] mx);
    next_addr = (a >= mx) ? '0 : ADDR_W'(a + 1'b1);
  endfunction

  // ----------------------------------------------------------
  // timers
  // ----------------------------------------------------------
  // reload on the first cycle out of reset so silence counts from release
  assign restart_dead = st.fresh || I_LINK_ACTIVITY || (st.state != TPN_IDLE);
  assign restart_reply = (st.state != TPN_WAIT) || I_LINK_ACTIVITY;

  tpn_timer #(.WIDTH(TMR_W)) u_dead (
    .I_CLK_SYS(I_CLK_SYS),
    .I_RESETN(I_RESETN),
    .i_restart(restart_dead),
    .i_load(DEAD_CYCLES),
    .o_expired(dead)
  );

  tpn_timer #(.WIDTH(TMR_W)) u_reply (
    .I_CLK_SYS(I_CLK_SYS),
    .I_RESETN(I_RESETN),
    .i_restart(restart_reply),
    .i_load(REPLY_CYCLES),
    .o_expired(reply_late)
  );

  // ----------------------------------------------------------
  // token state machine
  // ----------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.send_msg = 1'b0;
    next_st.send_pass = 1'b0;
    next_st.fresh = 1'b0;
    if (I_CFG_LOAD) begin
      // reject a zero responder address, a zero maximum address or a hold outside the limits
      if (!I_IS_INITIATOR && I_CFG_ADDR == '0) begin
        next_st.cfg_err = 1'b1;
      end else if (I_CFG_MAX_ADDR == '0 || I_CFG_HOLD < `TPN_HOLD_MIN
                   || I_CFG_HOLD > `TPN_HOLD_MAX) begin
        next_st.cfg_err = 1'b1;
      end else begin
        next_st.cfg_err = 1'b0;
        next_st.addr = I_CFG_ADDR;
        next_st.max_addr = I_CFG_MAX_ADDR;
        next_st.hold = I_CFG_HOLD;
      end
    end
    case (st.state)
      TPN_IDLE: begin
        if (I_TOKEN_RX) begin
          next_st.state = TPN_SEND;
          next_st.sent = '0;
          next_st.origin = 1'b0;
        end else if (dead && I_IS_INITIATOR) begin
          next_st.state = TPN_CLAIM;
          next_st.normal = 1'b0;
        end
      end
      TPN_CLAIM: begin
        // claimant originates network build
        next_st.origin = 1'b1;
        next_st.sent = st.hold;
        next_st.state = TPN_SEND;
      end
      TPN_SEND: begin
        if (I_MSG_PENDING && st.sent < st.hold) begin
          if (!st.send_msg) begin
            next_st.send_msg = 1'b1;
          end
          if (I_TX_DONE) begin
            next_st.sent = 3'(st.sent + 1'b1);
          end
        end else begin
          next_st.tries = '0;
          next_st.state = TPN_PASS;
          if (st.succ_ok) begin
            next_st.target = st.succ;
          end else begin
            next_st.target = next_addr(st.addr, st.max_addr);
          end
        end
      end
      TPN_PASS: begin
        if (st.target == st.addr) begin
          // search came back round to own address: ring complete
          next_st.normal = 1'b1;
          next_st.state = TPN_IDLE;
        end else begin
          next_st.send_pass = 1'b1;
          next_st.tries = 2'(st.tries + 1'b1);
          next_st.state = TPN_WAIT;
        end
      end
      TPN_WAIT: begin
        if (I_LINK_ACTIVITY) begin
          next_st.succ = st.target;
          next_st.succ_ok = 1'b1;
          next_st.state = TPN_IDLE;
        end else if (reply_late) begin
          if (st.tries < `TPN_PASS_TRIES) begin
            next_st.state = TPN_PASS;
          end else begin
            next_st.succ_ok = 1'b0;
            next_st.state = TPN_SRCH;
          end
        end
      end
      TPN_SRCH: begin
        next_st.tries = '0;
        next_st.target = next_addr(st.target, st.max_addr);
        next_st.state = TPN_PASS;
      end
      default: begin
        next_st.state = TPN_IDLE;
      end
    endcase
    if (st.origin && I_TOKEN_RX && st.state == TPN_IDLE) begin
      next_st.normal = 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      st <= '0;
      st.state <= TPN_IDLE;
      st.addr <= `TPN_RESET_ADDR;
      st.max_addr <= `TPN_MAX_ADDR_DEF;
      st.hold <= `TPN_HOLD_MIN;
      st.fresh <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------
  // outputs
  // ----------------------------------------------------------
  assign O_SEND_MSG = st.send_msg;
  assign O_SEND_PASS = st.send_pass;
  assign O_DEST_ADDR = st.target;
  assign O_NODE_ADDR = st.addr;
  assign O_MAX_ADDR = st.max_addr;
  assign O_HAS_TOKEN = (st.state != TPN_IDLE) && (st.state != TPN_WAIT);
  assign O_NET_NORMAL = st.normal;
  assign O_CFG_ERR = st.cfg_err;
endmodule // tpn_node
`default_nettype wire

/* File: include/tpn_defs.svh */
// constants for the token-pass network node
`ifndef TPN_DEFS_SVH
`define TPN_DEFS_SVH
`define TPN_ADDR_W 5
`define TPN_MAX_NODES 32
`define TPN_MAX_ADDR_DEF 5'h1f
`define TPN_RESET_ADDR 5'h01
`define TPN_PASS_TRIES 2'h3
`define TPN_HOLD_MIN 3'h1
`define TPN_HOLD_MAX 3'h4
`define TPN_DEAD_CYCLES 16'h2710
`define TPN_REPLY_CYCLES 16'h00c8
`endif

/* File: include/tpn_pkg.sv */
// types for the token-pass network node
`default_nettype none
package tpn_pkg;
  typedef enum logic [2:0] {
    TPN_IDLE  = 3'h0,
    TPN_CLAIM = 3'h1,
    TPN_SEND  = 3'h3,
    TPN_PASS  = 3'h2,
    TPN_WAIT  = 3'h6,
    TPN_SRCH  = 3'h7
  } tpn_state_t;
endpackage
`default_nettype wire

/* File: logic/tpn_timer.sv */
// down counter that restarts on link activity and flags expiry
`timescale 1ns/10ps
`default_nettype none
module tpn_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  // control
  input wire logic i_restart,
  input wire logic [WIDTH-1:0] i_load,
  // status
  output logic o_expired
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } tpn_tmr_t;
  tpn_tmr_t st;
  tpn_tmr_t next_st;

  always_comb begin
    next_st = st;
    if (i_restart) begin
      next_st.cnt = i_load;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_expired = (st.cnt == '0) && !i_restart;
endmodule // tpn_timer
`default_nettype wire

/* File: tb/tpn_node_assertions.sv */
// assertions on the token-pass node ports
`timescale 1ns/10ps
`default_nettype none
module tpn_node_assertions (
  input wire logic I_CLK_SYS, I_RESETN, I_IS_INITIATOR, I_CFG_LOAD, I_TOKEN_RX,
  input wire logic [4:0] I_CFG_ADDR, I_CFG_MAX_ADDR,
  input wire logic [2:0] I_CFG_HOLD,
  input wire logic O_SEND_MSG, O_SEND_PASS, O_HAS_TOKEN, O_NET_NORMAL, O_CFG_ERR,
  input wire logic [4:0] O_DEST_ADDR, O_NODE_ADDR, O_MAX_ADDR
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);
  logic ok;
  logic got_tok;
  assign ok = I_CFG_HOLD inside {[3'h1:3'h4]} && I_CFG_MAX_ADDR != 5'h0 &&
    (I_IS_INITIATOR || I_CFG_ADDR != 5'h0);
  // a node that has held a token may legally retry a pass later
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      got_tok <= 1'b0;
    end else if (I_TOKEN_RX) begin
      got_tok <= 1'b1;
    end
  end
  a_reset_addr: assert property ($rose(I_RESETN) |->
    O_NODE_ADDR == 5'h01 && O_MAX_ADDR == 5'h1f) else $error("reset address");
  a_msg_pulse: assert property (O_SEND_MSG |=> !O_SEND_MSG)
    else $error("message pulse");
  a_pass_pulse: assert property (O_SEND_PASS |=> !O_SEND_PASS)
    else $error("pass pulse");
  a_resp_silent: assert property (!I_IS_INITIATOR && !got_tok && !O_HAS_TOKEN
    && !I_TOKEN_RX |=> !O_HAS_TOKEN) else $error("responder took token");
  a_pass_target: assert property (O_SEND_PASS |-> O_DEST_ADDR <= O_MAX_ADDR
    && O_DEST_ADDR != O_NODE_ADDR) else $error("pass target");
  a_cfg_reject: assert property (I_CFG_LOAD && !ok |=> O_CFG_ERR
    && $stable(O_NODE_ADDR)) else $error("config not refused");
  a_cfg_take: assert property (I_CFG_LOAD && ok |=> !O_CFG_ERR
    && O_NODE_ADDR == $past(I_CFG_ADDR)) else $error("config not taken");
  a_token_take: assert property (I_TOKEN_RX && !O_HAS_TOKEN |=> O_HAS_TOKEN)
    else $error("token not taken");
  cover property (O_SEND_PASS);
  cover property ($rose(O_NET_NORMAL));
  cover property ($rose(O_CFG_ERR));
endmodule // tpn_node_assertions
bind tpn_node tpn_node_assertions u_chk (.*);
`default_nettype wire

/* File: tb/tpn_link_model.sv */
// stand-in for the other nodes on the shared link
`timescale 1ns/10ps
`default_nettype none
module tpn_link_model #(
  parameter logic [31:0] PRESENT = 32'h1
) (
  input wire logic I_CLK_SYS, O_SEND_MSG, O_SEND_PASS,
  input wire logic [4:0] O_DEST_ADDR,
  output logic I_LINK_ACTIVITY = 1'b0, I_TOKEN_RX = 1'b0, I_TX_DONE = 1'b0
);
  logic [3:0] cnt = 4'h0;
  always @(negedge I_CLK_SYS) begin
    I_TX_DONE <= O_SEND_MSG;
    I_LINK_ACTIVITY <= cnt == 4'h7; // successor answers
    I_TOKEN_RX <= cnt == 4'h1; // token comes back round the ring
    if (cnt != 4'h0) cnt <= cnt - 4'h1;
    if (O_SEND_PASS && PRESENT[O_DEST_ADDR]) cnt <= 4'h8; // only listed nodes reply
  end
endmodule // tpn_link_model
`default_nettype wire

/* File: tb/test_token_pass_network_init.sv */
// self-checking bench for the token-pass node
`timescale 1ns/10ps
`default_nettype none
module test_token_pass_network_init;
  logic I_CLK_SYS = 1'b0, I_RESETN = 1'b0, I_IS_INITIATOR = 1'b0, I_CFG_LOAD = 1'b0;
  logic I_MSG_PENDING = 1'b1;
  logic [4:0] I_CFG_ADDR = 5'h0, I_CFG_MAX_ADDR = 5'h1f, O_DEST_ADDR, O_NODE_ADDR, O_MAX_ADDR;
  logic [2:0] I_CFG_HOLD = 3'h1;
  logic I_LINK_ACTIVITY, I_TOKEN_RX, I_TX_DONE, O_SEND_MSG, O_SEND_PASS;
  logic O_HAS_TOKEN, O_NET_NORMAL, O_CFG_ERR;
  int num_errors = 0, n_checks = 0;
  always #25 I_CLK_SYS = ~I_CLK_SYS;
  tpn_node #(.DEAD_CYCLES(16'h0014), .REPLY_CYCLES(16'h0005)) u_dut (.*);
  tpn_link_model u_link (.*);
  task automatic check(input logic [4:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_pass(output logic [4:0] d, output int msgs);
    int i;
    msgs = 0;
    for (i = 0; i < 400 && O_SEND_PASS !== 1'b1; i++) begin
      if (O_SEND_MSG === 1'b1) begin
        msgs++;
      end
      @(negedge I_CLK_SYS);
    end
    if (i == 400) begin
      check({4'h0, O_SEND_PASS}, 5'h01);
      complete_run();
    end
    d = O_DEST_ADDR;
    @(negedge I_CLK_SYS);
  endtask
  task automatic load(input logic [4:0] a, m, input logic [2:0] h, input logic e);
    I_CFG_ADDR = a;
    I_CFG_MAX_ADDR = m;
    I_CFG_HOLD = h;
    I_CFG_LOAD = 1'b1;
    @(negedge I_CLK_SYS);
    I_CFG_LOAD = 1'b0;
    @(negedge I_CLK_SYS);
    check({4'h0, O_CFG_ERR}, {4'h0, e});
  endtask
  task automatic t_config;
    load(5'h0, 5'h1f, 3'h1, 1'b1);
    load(5'h2, 5'h1f, 3'h5, 1'b1);
    load(5'h2, 5'h00, 3'h4, 1'b1);
    check(O_NODE_ADDR, 5'h01);
    load(5'h3, 5'h06, 3'h4, 1'b0);
    check(O_NODE_ADDR, 5'h03);
    check(O_MAX_ADDR, 5'h06);
    $display("config test done");
  endtask
  task automatic t_ring;
    logic [4:0] d, exp;
    int m;
    exp = 5'h03;
    I_IS_INITIATOR = 1'b1;
    for (int k = 0; k < 10; k++) begin
      if (k % 3 == 0) exp = (exp == 5'h06) ? 5'h00 : exp + 5'h01;
      wait_pass(d, m);
      check(d, exp);
    end
    for (int k = 0; k < 40 && O_NET_NORMAL !== 1'b1; k++) @(negedge I_CLK_SYS);
    check({4'h0, O_NET_NORMAL}, 5'h01);
    if (O_NET_NORMAL !== 1'b1) begin
      complete_run();
    end
    wait_pass(d, m);
    check(d, 5'h00);
    check(5'(m), 5'h04);
    $display("ring test done");
  endtask
  task automatic t_reset;
    repeat (2) @(negedge I_CLK_SYS);
    I_RESETN = 1'b1;
    @(negedge I_CLK_SYS);
    check(O_NODE_ADDR, 5'h01);
    check(O_MAX_ADDR, 5'h1f);
    $display("reset test done");
  endtask
  task automatic t_responder;
    repeat (60) begin
      @(negedge I_CLK_SYS);
      check({3'h0, O_SEND_PASS, O_HAS_TOKEN}, 5'h0);
    end
    $display("responder test done");
  endtask
  // mid-run reset, then count edges to the claim: load, 20 silent, claim
  task automatic t_claim_time;
    int n;
    I_RESETN = 1'b0;
    repeat (12) @(negedge I_CLK_SYS);
    I_RESETN = 1'b1;
    check(O_NODE_ADDR, 5'h01);
    check({4'h0, O_NET_NORMAL}, 5'h00);
    for (n = 0; n < 40 && O_HAS_TOKEN !== 1'b1; n++) begin
      @(negedge I_CLK_SYS);
    end
    check(5'(n), 5'h16);
    if (n == 40) begin
      complete_run();
    end
    load(5'h00, 5'h1f, 3'h1, 1'b0);
    check(O_NODE_ADDR, 5'h00);
    $display("claim timing test done");
  endtask
  initial begin
    t_reset();
    t_config();
    t_responder();
    t_ring();
    t_claim_time();
    complete_run();
  end
endmodule // test_token_pass_network_init
`default_nettype wire
